// >>> include/e3rl_pkg.sv
// constants shared by the receive status latch block
package e3rl_pkg;
   // ==========================================================
   // register indices, byte address is four times the index
   localparam int unsigned ADDR_W = 12;
   localparam logic [9:0] IDX_STATUS_ONE = 10'h124;
   localparam logic [9:0] IDX_STATUS_TWO = 10'h126;
   localparam logic [9:0] IDX_LATCH_ONE  = 10'h128;
   localparam logic [9:0] IDX_LATCH_TWO  = 10'h12a;
   localparam logic [9:0] IDX_ENABLE_ONE = 10'h12c;
   localparam logic [9:0] IDX_ENABLE_TWO = 10'h12e;
   localparam logic [9:0] IDX_PORT_EN    = 10'h140;
   // ==========================================================
   // implemented bits and reset values
   localparam logic [15:0] MASK_ONE    = 16'h3dff;
   localparam logic [15:0] MASK_TWO    = 16'h0707;
   localparam logic [15:0] MASK_STAT1  = 16'h191f;
   localparam logic [15:0] MASK_STAT2  = 16'h0007;
   localparam logic [15:0] RESET_WORD  = 16'h0000;
   // ==========================================================
   // field positions in the first latched register
   localparam int unsigned B1_CLOCK_SRC = 13;
   localparam int unsigned B1_UNSTABLE  = 12;
   localparam int unsigned B1_MISMATCH  = 11;
   localparam int unsigned B1_PAYLOAD   = 10;
   localparam int unsigned B1_ONES      = 8;
   localparam int unsigned B1_GC        = 7;
   localparam int unsigned B1_NR        = 6;
   localparam int unsigned B1_ALIGN     = 5;
   // second latched register
   localparam int unsigned B2_REMOTE    = 10;
   localparam int unsigned B2_PARITY    = 9;
   localparam int unsigned B2_FRAMING   = 8;
   // ==========================================================
   // change detector vector layout, count of settle cycles
   localparam int unsigned DV_WIDTH  = 34;
   localparam int unsigned DV_ALARM  = 3;
   localparam int unsigned DV_ONES   = 8;
   localparam int unsigned DV_MISM   = 9;
   localparam int unsigned DV_UNST   = 10;
   localparam int unsigned DV_NR     = 11;
   localparam int unsigned DV_GC     = 19;
   localparam int unsigned DV_PT     = 27;
   localparam int unsigned DV_TS     = 30;
   localparam logic [1:0] PRIME_CYCLES = 2'h2;
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : e3rl_pkg

// >>> rtl/e3rl_delta.sv
// per-bit change and rising-edge detector
`timescale 1ns/1ps
`default_nettype none
module e3rl_delta #(
   parameter int unsigned WIDTH = 34
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] chg,
   output logic      [WIDTH-1:0] rise
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [WIDTH-1:0] prev;
      logic [1:0]       settle;
   } e3rl_delta_type;
   e3rl_delta_type s_q, s_d;

   if (WIDTH < 1) begin : g_chk
      $error("e3rl_delta: WIDTH must be at least one");
   end

   // settle counter hides the first load after reset
   always_comb begin
      s_d = s_q;
      s_d.prev = din;
      if (s_q.settle != e3rl_pkg::PRIME_CYCLES) begin
         s_d.settle = s_q.settle + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // one detector per bit
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      assign chg[i]  = (s_q.settle == e3rl_pkg::PRIME_CYCLES) && (din[i] != s_q.prev[i]);
      assign rise[i] = chg[i] && din[i];
   end
endmodule : e3rl_delta
`default_nettype wire

// >>> rtl/e3rl_top.sv
// receive status latches, enables and interrupt with AXI4-Lite access
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module e3rl_top #(
   parameter int unsigned ALIGN_W = 10,
   parameter int unsigned COUNT_W = 16
) (
   input  wire logic                       CORE_CLK,
   input  wire logic                       RST_N,
   input  wire logic                       S_AXI_AWVALID,
   output logic                            S_AXI_AWREADY,
   input  wire logic [e3rl_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic [2:0]                 S_AXI_AWPROT,
   input  wire logic                       S_AXI_WVALID,
   output logic                            S_AXI_WREADY,
   input  wire logic [31:0]                S_AXI_WDATA,
   input  wire logic [3:0]                 S_AXI_WSTRB,
   output logic                            S_AXI_BVALID,
   input  wire logic                       S_AXI_BREADY,
   output logic [1:0]                      S_AXI_BRESP,
   input  wire logic                       S_AXI_ARVALID,
   output logic                            S_AXI_ARREADY,
   input  wire logic [e3rl_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic [2:0]                 S_AXI_ARPROT,
   output logic                            S_AXI_RVALID,
   input  wire logic                       S_AXI_RREADY,
   output logic [31:0]                     S_AXI_RDATA,
   output logic [1:0]                      S_AXI_RRESP,
   input  wire logic [3:0]                 CLOCK_SOURCE_CODE,
   input  wire logic [2:0]                 PAYLOAD_TYPE_FIELD,
   input  wire logic                       PAYLOAD_UNSTABLE,
   input  wire logic                       PAYLOAD_MISMATCH,
   input  wire logic                       UNFRAMED_ALL_ONES,
   input  wire logic [7:0]                 GENERAL_CHANNEL_BYTE,
   input  wire logic [7:0]                 NETWORK_REQ_BYTE,
   input  wire logic                       FRAME_LOST,
   input  wire logic                       REMOTE_DEFECT,
   input  wire logic                       ALARM_INDICATION,
   input  wire logic                       OUT_OF_FRAME,
   input  wire logic                       SIGNAL_ABSENT_INPUT,
   input  wire logic                       ALIGN_LOAD,
   input  wire logic [ALIGN_W-1:0]         ALIGN_POS,
   input  wire logic                       REMOTE_ERROR_DET,
   input  wire logic                       PARITY_ERROR_DET,
   input  wire logic                       FRAMING_ERROR_DET,
   input  wire logic [COUNT_W-1:0]         REMOTE_COUNT,
   input  wire logic [COUNT_W-1:0]         PARITY_COUNT,
   input  wire logic [COUNT_W-1:0]         FRAMING_COUNT,
   output logic                            IRQ
);
   // ==========================================================
   // state of the whole block
   typedef struct packed {
      logic [15:0]        stat1;
      logic [15:0]        stat2;
      logic [3:0]         ts;
      logic [2:0]         pt;
      logic [7:0]         gc;
      logic [7:0]         nr;
      logic [15:0]        latch1;
      logic [15:0]        latch2;
      logic [15:0]        en1;
      logic [15:0]        en2;
      logic               port_en;
      logic [ALIGN_W-1:0] align_last;
      logic               align_valid;
      logic               aw_have;
      logic               w_have;
      logic [9:0]         widx;
      logic [15:0]        wdata;
      logic [1:0]         wstrb;
      logic               awready;
      logic               wready;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arready;
      logic               rvalid;
      logic [15:0]        rdata;
      logic [1:0]         rresp;
      logic               irq;
   } e3rl_state_type;
   e3rl_state_type s_q, s_d;

   if (ALIGN_W < 1 || COUNT_W < 1) begin : g_chk
      $error("e3rl_top: ALIGN_W and COUNT_W must be at least one");
   end

   // ==========================================================
   // change detection on the registered live status
   logic [e3rl_pkg::DV_WIDTH-1:0] dv;
   logic [e3rl_pkg::DV_WIDTH-1:0] dchg;
   logic [e3rl_pkg::DV_WIDTH-1:0] drise;

   assign dv = {s_q.ts, s_q.pt, s_q.gc, s_q.nr, s_q.stat1[12], s_q.stat1[11],
                s_q.stat1[8], s_q.stat1[4:0], s_q.stat2[2:0]};

   e3rl_delta #(
      .WIDTH (e3rl_pkg::DV_WIDTH)
   ) u_delta (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .din   (dv),
      .chg   (dchg),
      .rise  (drise)
   );

   // ==========================================================
   // event vectors for the two latched registers
   logic [15:0] ev1;
   logic [15:0] ev2;
   logic        align_evt;

   // first alignment after reset has nothing to differ from
   assign align_evt = ALIGN_LOAD && s_q.align_valid && (ALIGN_POS != s_q.align_last);

   always_comb begin
      ev1 = '0;
      ev1[e3rl_pkg::B1_CLOCK_SRC] = |dchg[e3rl_pkg::DV_TS +: 4];
      ev1[e3rl_pkg::B1_UNSTABLE]  = drise[e3rl_pkg::DV_UNST];
      ev1[e3rl_pkg::B1_MISMATCH]  = drise[e3rl_pkg::DV_MISM];
      ev1[e3rl_pkg::B1_PAYLOAD]   = |dchg[e3rl_pkg::DV_PT +: 3];
      ev1[e3rl_pkg::B1_ONES]      = dchg[e3rl_pkg::DV_ONES];
      ev1[e3rl_pkg::B1_GC]        = |dchg[e3rl_pkg::DV_GC +: 8];
      ev1[e3rl_pkg::B1_NR]        = |dchg[e3rl_pkg::DV_NR +: 8];
      ev1[e3rl_pkg::B1_ALIGN]     = align_evt;
      ev1[4:0]                    = dchg[e3rl_pkg::DV_ALARM +: 5];
      ev2 = '0;
      ev2[e3rl_pkg::B2_REMOTE]    = REMOTE_ERROR_DET;
      ev2[e3rl_pkg::B2_PARITY]    = PARITY_ERROR_DET;
      ev2[e3rl_pkg::B2_FRAMING]   = FRAMING_ERROR_DET;
      ev2[2:0]                    = drise[2:0];
   end

   // ==========================================================
   // bus write and read decode helpers
   logic        wr_fire;
   logic [15:0] bmask;
   logic [15:0] wbits;
   logic        ar_fire;
   logic [9:0]  ridx;

   assign wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
   assign bmask   = {{8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
   assign wbits   = s_q.wdata & bmask;
   assign ar_fire = S_AXI_ARVALID && s_q.arready;
   assign ridx    = S_AXI_ARADDR[e3rl_pkg::ADDR_W-1:2];

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      // live status sampling; unimplemented bits stay zero
      s_d.stat1 = '0;
      s_d.stat1[12] = PAYLOAD_UNSTABLE;
      s_d.stat1[11] = PAYLOAD_MISMATCH;
      s_d.stat1[8]  = UNFRAMED_ALL_ONES;
      s_d.stat1[4]  = FRAME_LOST;
      s_d.stat1[3]  = REMOTE_DEFECT;
      s_d.stat1[2]  = ALARM_INDICATION;
      s_d.stat1[1]  = OUT_OF_FRAME;
      s_d.stat1[0]  = SIGNAL_ABSENT_INPUT;
      s_d.stat2 = '0;
      s_d.stat2[2] = (REMOTE_COUNT != '0);
      s_d.stat2[1] = (PARITY_COUNT != '0);
      s_d.stat2[0] = (FRAMING_COUNT != '0);
      s_d.ts = CLOCK_SOURCE_CODE;
      s_d.pt = PAYLOAD_TYPE_FIELD;
      s_d.gc = GENERAL_CHANNEL_BYTE;
      s_d.nr = NETWORK_REQ_BYTE;
      // alignment memory
      if (ALIGN_LOAD) begin
         s_d.align_last  = ALIGN_POS;
         s_d.align_valid = 1'b1;
      end

      // write address and data are taken in either order
      if (S_AXI_AWVALID && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.widx    = S_AXI_AWADDR[e3rl_pkg::ADDR_W-1:2];
      end
      if (S_AXI_WVALID && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.wdata  = S_AXI_WDATA[15:0];
         s_d.wstrb  = S_AXI_WSTRB[1:0];
      end

      // latches: set wins over a same-cycle clear
      s_d.latch1 = s_q.latch1 | ev1;
      s_d.latch2 = s_q.latch2 | ev2;
      if (wr_fire) begin
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = e3rl_pkg::RESP_OKAY;
         if (s_q.widx == e3rl_pkg::IDX_LATCH_ONE) begin
            s_d.latch1 = (s_q.latch1 & ~wbits) | ev1;
         end else if (s_q.widx == e3rl_pkg::IDX_LATCH_TWO) begin
            s_d.latch2 = (s_q.latch2 & ~wbits) | ev2;
         end else if (s_q.widx == e3rl_pkg::IDX_ENABLE_ONE) begin
            s_d.en1 = ((s_q.en1 & ~bmask) | wbits) & e3rl_pkg::MASK_ONE;
         end else if (s_q.widx == e3rl_pkg::IDX_ENABLE_TWO) begin
            s_d.en2 = ((s_q.en2 & ~bmask) | wbits) & e3rl_pkg::MASK_TWO;
         end else if (s_q.widx == e3rl_pkg::IDX_PORT_EN) begin
            if (s_q.wstrb[0]) begin
               s_d.port_en = s_q.wdata[0];
            end
         end else if (s_q.widx == e3rl_pkg::IDX_STATUS_ONE ||
                      s_q.widx == e3rl_pkg::IDX_STATUS_TWO) begin
            s_d.bresp = e3rl_pkg::RESP_OKAY;                    // read-only, ignored
         end else begin
            s_d.bresp = e3rl_pkg::RESP_SLVERR;
         end
      end
      s_d.latch1 = s_d.latch1 & e3rl_pkg::MASK_ONE;
      s_d.latch2 = s_d.latch2 & e3rl_pkg::MASK_TWO;
      if (s_q.bvalid && S_AXI_BREADY) begin
         s_d.bvalid = 1'b0;
      end
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready  = !s_d.w_have && !s_d.bvalid;

      // read: answer one cycle after the address is taken
      if (ar_fire) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = e3rl_pkg::RESP_OKAY;
         if (ridx == e3rl_pkg::IDX_STATUS_ONE) begin
            s_d.rdata = s_q.stat1;
         end else if (ridx == e3rl_pkg::IDX_STATUS_TWO) begin
            s_d.rdata = s_q.stat2;
         end else if (ridx == e3rl_pkg::IDX_LATCH_ONE) begin
            s_d.rdata = s_q.latch1;
         end else if (ridx == e3rl_pkg::IDX_LATCH_TWO) begin
            s_d.rdata = s_q.latch2;
         end else if (ridx == e3rl_pkg::IDX_ENABLE_ONE) begin
            s_d.rdata = s_q.en1;
         end else if (ridx == e3rl_pkg::IDX_ENABLE_TWO) begin
            s_d.rdata = s_q.en2;
         end else if (ridx == e3rl_pkg::IDX_PORT_EN) begin
            s_d.rdata = {15'h0000, s_q.port_en};
         end else begin
            s_d.rdata = '0;
            s_d.rresp = e3rl_pkg::RESP_SLVERR;
         end
      end else if (s_q.rvalid && S_AXI_RREADY) begin
         s_d.rvalid = 1'b0;
      end
      s_d.arready = !s_d.rvalid;

      // interrupt: positionwise gating, then the port enable
      s_d.irq = s_q.port_en &&
                (|(s_q.latch1 & s_q.en1) || |(s_q.latch2 & s_q.en2));
   end

   // ==========================================================
   // state register
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs straight from flip-flops
   assign S_AXI_AWREADY = s_q.awready;
   assign S_AXI_WREADY  = s_q.wready;
   assign S_AXI_BVALID  = s_q.bvalid;
   assign S_AXI_BRESP   = s_q.bresp;
   assign S_AXI_ARREADY = s_q.arready;
   assign S_AXI_RVALID  = s_q.rvalid;
   assign S_AXI_RDATA   = {16'h0000, s_q.rdata};
   assign S_AXI_RRESP   = s_q.rresp;
   assign IRQ           = s_q.irq;

   // ==========================================================
   // checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   a_clock_source_set: assert property (
      |dchg[e3rl_pkg::DV_TS +: 4] |=> s_q.latch1[e3rl_pkg::B1_CLOCK_SRC])
      else $error("clock source change not latched");
   a_unstable_rise: assert property (
      !drise[e3rl_pkg::DV_UNST] && !s_q.latch1[e3rl_pkg::B1_UNSTABLE]
      |=> s_q.latch1[e3rl_pkg::B1_UNSTABLE] == $past(drise[e3rl_pkg::DV_UNST]))
      else $error("unstable latch set without rising edge");
   a_mismatch_rise: assert property (
      $rose(s_q.stat1[11]) && u_delta.s_q.settle == e3rl_pkg::PRIME_CYCLES
      |=> s_q.latch1[e3rl_pkg::B1_MISMATCH])
      else $error("mismatch rise not latched");
   a_payload_change: assert property (
      $changed(s_q.pt) && u_delta.s_q.settle == e3rl_pkg::PRIME_CYCLES
      |=> s_q.latch1[e3rl_pkg::B1_PAYLOAD])
      else $error("payload type change not latched");
   a_ones_change: assert property (
      $changed(s_q.stat1[8]) && u_delta.s_q.settle == e3rl_pkg::PRIME_CYCLES
      |=> s_q.latch1[e3rl_pkg::B1_ONES])
      else $error("unframed ones change not latched");
   a_gc_change: assert property (
      u_delta.s_q.settle == e3rl_pkg::PRIME_CYCLES && $changed(s_q.gc)
      |=> s_q.latch1[e3rl_pkg::B1_GC])
      else $error("general channel change not latched");
   a_nr_change: assert property (
      u_delta.s_q.settle == e3rl_pkg::PRIME_CYCLES && $changed(s_q.nr)
      |=> s_q.latch1[e3rl_pkg::B1_NR])
      else $error("network requirement change not latched");
   a_align_change: assert property (
      ALIGN_LOAD && s_q.align_valid && ALIGN_POS != s_q.align_last
      |=> s_q.latch1[e3rl_pkg::B1_ALIGN])
      else $error("alignment change not latched");
   a_alarm_change: assert property (
      |dchg[7:3] |=> (s_q.latch1[4:0] & $past(dchg[7:3])) == $past(dchg[7:3]))
      else $error("alarm change not latched");
   a_event_latch: assert property (
      REMOTE_ERROR_DET || PARITY_ERROR_DET || FRAMING_ERROR_DET
      |=> (s_q.latch2[10:8] & $past({REMOTE_ERROR_DET, PARITY_ERROR_DET,
           FRAMING_ERROR_DET})) == $past({REMOTE_ERROR_DET, PARITY_ERROR_DET,
           FRAMING_ERROR_DET}))
      else $error("error event not latched");
   a_count_rise: assert property (
      |drise[2:0] |=> (s_q.latch2[2:0] & $past(drise[2:0])) == $past(drise[2:0]))
      else $error("count rise not latched");
   a_irq_gate: assert property (
      ##1 IRQ == $past(s_q.port_en && (|(s_q.latch1 & s_q.en1) ||
                                        |(s_q.latch2 & s_q.en2))))
      else $error("interrupt does not follow gating");
   a_count_level: assert property (
      ##1 s_q.stat2[2] == ($past(REMOTE_COUNT) != '0))
      else $error("remote count nonzero wrong");
   a_los_mirror: assert property (
      ##1 s_q.stat1[0] == $past(SIGNAL_ABSENT_INPUT))
      else $error("signal absent does not mirror input");
   a_latch_hold: assert property (
      !wr_fire |=> (s_q.latch1 & $past(s_q.latch1)) == $past(s_q.latch1))
      else $error("latch lost without write");
   a_reserved_zero: assert property (
      (s_q.latch1 & ~e3rl_pkg::MASK_ONE) == '0 && (s_q.en1 & ~e3rl_pkg::MASK_ONE) == '0
      && (s_q.latch2 & ~e3rl_pkg::MASK_TWO) == '0)
      else $error("reserved bit set");

   c_irq_raise: cover property ($rose(IRQ));
   c_clear_write: cover property (wr_fire && s_q.widx == e3rl_pkg::IDX_LATCH_ONE);
   c_read_latch: cover property (ar_fire && ridx == e3rl_pkg::IDX_LATCH_TWO);
   c_align_event: cover property (align_evt);
endmodule : e3rl_top
`default_nettype wire

// >>> tb/e3_rx_status_latch_irq_tb_top.sv
// self-checking bench for the receive status latch block
`timescale 1ns/1ps
`default_nettype none
module e3_rx_status_latch_irq_tb_top;
   localparam logic [11:0] A_S1 = {e3rl_pkg::IDX_STATUS_ONE, 2'b00};
   localparam logic [11:0] A_S2 = {e3rl_pkg::IDX_STATUS_TWO, 2'b00};
   localparam logic [11:0] A_L1 = {e3rl_pkg::IDX_LATCH_ONE, 2'b00};
   localparam logic [11:0] A_L2 = {e3rl_pkg::IDX_LATCH_TWO, 2'b00};
   localparam logic [11:0] A_E1 = {e3rl_pkg::IDX_ENABLE_ONE, 2'b00};
   localparam logic [11:0] A_E2 = {e3rl_pkg::IDX_ENABLE_TWO, 2'b00};
   localparam logic [11:0] A_PE = {e3rl_pkg::IDX_PORT_EN, 2'b00};
   logic        clk, rst_n, awv, wv, br, arv, rr, ld, red, ped, fed;
   logic        pu, pm, ua, fl, rdf, ai, oo, sa, awr, wrdy, bv, arr, rv, irq;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdat;
   logic [3:0]  ws, csc;
   logic [2:0]  pt;
   logic [7:0]  gc, nr;
   logic [9:0]  ap;
   logic [15:0] rc, pc, fc;
   logic [1:0]  bresp, rresp;
   int          n_errors, cmp_count, cyc;
   // change kind and expected latches {two, one} per step
   int          ks[25] = '{0, 1, 1, 2, 2, 3, 4, 4, 5, 6, 13, 12, 13, 7, 8, 9, 10, 11, 14, 15, 16,
                           17, 17, 18, 19};
   logic [31:0] es[25] = '{'h2000, 'h1000, 0, 'h800, 0, 'h400, 'h100, 'h100, 'h80, 'h40, 0,
                           'h20, 0, 'h10, 8, 4, 2, 1, 'h4000000, 'h2000000, 'h1000000,
                           'h40000, 0, 'h20000, 'h10000};

   e3rl_top u_e3rl_top (.CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(br), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
      .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .CLOCK_SOURCE_CODE(csc),
      .PAYLOAD_TYPE_FIELD(pt), .PAYLOAD_UNSTABLE(pu), .PAYLOAD_MISMATCH(pm),
      .UNFRAMED_ALL_ONES(ua), .GENERAL_CHANNEL_BYTE(gc), .NETWORK_REQ_BYTE(nr),
      .FRAME_LOST(fl), .REMOTE_DEFECT(rdf), .ALARM_INDICATION(ai), .OUT_OF_FRAME(oo),
      .SIGNAL_ABSENT_INPUT(sa), .ALIGN_LOAD(ld), .ALIGN_POS(ap), .REMOTE_ERROR_DET(red),
      .PARITY_ERROR_DET(ped), .FRAMING_ERROR_DET(fed), .REMOTE_COUNT(rc),
      .PARITY_COUNT(pc), .FRAMING_COUNT(fc), .IRQ(irq));

   // ==========================================================
   // clock, watchdog and reporting
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // a hang counts as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp
   // ==========================================================
   // bus tasks, each request held until its own ready
   task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
      {awv, wv, br} <= 3'h7;
      awa <= a;
      wd <= {16'h0000, d};
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while (!bv);
      br <= 1'b0;
      cmp({30'h0, bresp}, {30'h0, er});
      // idle edge: a following call must not raise bready in this same step
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0,
                     input logic [31:0] m = 32'hffff_ffff);
      {arv, rr} <= 2'h3;
      ara <= a;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rr <= 1'b0;
      cmp(rdat & m, e);
      cmp({30'h0, rresp}, {30'h0, er});
      // idle edge: a following call must not raise rready in this same step
      @(posedge clk);
   endtask : rd
   // ==========================================================
   // one status change, then both latches read and cleared
   task automatic step(input int k, input logic [31:0] e);
      case (k)
         0: csc <= csc + 4'h1;
         1: pu <= ~pu;
         2: pm <= ~pm;
         3: pt <= pt + 3'h1;
         4: ua <= ~ua;
         5: gc <= gc + 8'h01;
         6: nr <= nr + 8'h01;
         7: fl <= ~fl;
         8: rdf <= ~rdf;
         9: ai <= ~ai;
         10: oo <= ~oo;
         11: sa <= ~sa;
         12: {ld, ap} <= {1'b1, ~ap};
         13: ld <= 1'b1;
         14: red <= 1'b1;
         15: ped <= 1'b1;
         16: fed <= 1'b1;
         17: rc <= rc ^ 16'h0001;
         18: pc <= pc ^ 16'h0001;
         default: fc <= fc ^ 16'h0001;
      endcase
      @(posedge clk);
      {ld, red, ped, fed} <= 4'h0;
      repeat (3) @(posedge clk);
      rd(A_L1, {16'h0, e[15:0]});
      rd(A_L2, {16'h0, e[31:16]});
      wr(A_L1, 16'hffff);
      wr(A_L2, 16'hffff);
   endtask : step
   // ==========================================================
   // main sequence
   initial begin
      rst_n = 1'b0;
      {awv, wv, br, arv, rr, ld, red, ped, fed} = '0;
      {pu, pm, ua, fl, rdf, ai, oo, sa} = '0;
      {awa, ara, wd, csc, pt, gc, nr, ap, rc, pc, fc} = '0;
      ws = 4'hf;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // register map, reserved bits, unmapped place
      rd(A_E1, 32'h0);
      wr(A_E1, 16'hffff);
      rd(A_E1, {16'h0, e3rl_pkg::MASK_ONE});
      wr(A_E2, 16'hffff);
      rd(A_E2, {16'h0, e3rl_pkg::MASK_TWO});
      wr(12'h7f0, 16'hffff, e3rl_pkg::RESP_SLVERR);
      rd(12'h7f0, 32'h0, e3rl_pkg::RESP_SLVERR);
      wr(A_E1, 16'h0000);
      wr(A_E2, 16'h0000);
      foreach (ks[i]) step(ks[i], es[i]);
      rd(A_S1, 32'h1, 2'h0, 32'h1);
      rc <= 16'h0100;
      repeat (3) @(posedge clk);
      rd(A_S2, 32'h4, 2'h0, 32'h4);
      // interrupt gating by enable and port enable
      wr(A_E1, 16'h0001);
      sa <= ~sa;
      repeat (5) @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      wr(A_PE, 16'h0001);
      repeat (2) @(posedge clk);
      cmp({31'h0, irq}, 32'h1);
      wr(A_L1, 16'h0000);
      rd(A_L1, 32'h1);
      wr(A_E1, 16'h0000);
      repeat (2) @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      wr(A_E1, 16'h0001);
      wr(A_L1, 16'h0001);
      wr(A_L2, 16'hffff);
      repeat (2) @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      wr(A_E2, 16'h0400);
      red <= 1'b1;
      @(posedge clk);
      red <= 1'b0;
      repeat (3) @(posedge clk);
      cmp({31'h0, irq}, 32'h1);
      print_verdict();
   end
endmodule : e3_rx_status_latch_irq_tb_top
`default_nettype wire
